// *** src/isoch_dma_context_control.sv ***
// APB register block and context control for one transmit and one receive context
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "isoch_dma_params.svh"
// Operation
// - Gated transmit starts on matching cycle
// - Transmit start value is bits 30:16
// - Run changes only by software or reset
// - Descriptor fetch clears wake
// - Fatal sets dead; run clear clears it
// - Active high while processing descriptors
// - Completion code latched on finish
// - Each context has descriptor pointer register
// - Strides: receive 32, transmit 16 bytes
// - Packed mode steers buffer packing
// - Header mode keeps header, stamps packet
// - Receive gate waits match, clears on active
// - Multi-channel uses masks, else one channel
// - Receive speed code stored per packet
// - Tag enables admit matching tags
// - Receive match cycle in bits 24:12
// - Sync compared when wait field is 11
// - Tag one sync filter needs top 00
// - Channel select in bits 5:0
module isoch_dma_context_control #(
    parameter int TX_CTX = 0,
    parameter int RX_CTX = 0
) (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [15:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        soft_reset,
    input  wire isoch_dma_pkg::cycle_start_s cyc,
    input  wire isoch_dma_pkg::ctx_evt_s     tx_evt,
    input  wire isoch_dma_pkg::ctx_evt_s     rx_evt,
    input  wire isoch_dma_pkg::rx_pkt_s      rx_pkt,
    input  wire logic                        rx_wait_sync,
    output logic                             tx_active,
    output logic      [31:0]                 tx_pointer,
    output logic                             rx_active,
    output logic      [31:0]                 rx_pointer,
    output logic                             packed_buffer_mode,
    output logic                             keep_header_mode,
    output logic                             rx_accept,
    output logic      [15:0]                 rx_timestamp
);
    // Byte addresses of this context pair
    localparam logic [15:0] A_TXS = 16'(`TX_CTL_SET + `TX_STRIDE * TX_CTX);
    localparam logic [15:0] A_TXC = 16'(`TX_CTL_CLR + `TX_STRIDE * TX_CTX);
    localparam logic [15:0] A_TXP = 16'(`TX_PTR + `TX_STRIDE * TX_CTX);
    localparam logic [15:0] A_RXS = 16'(`RX_CTL_SET + `RX_STRIDE * RX_CTX);
    localparam logic [15:0] A_RXC = 16'(`RX_CTL_CLR + `RX_STRIDE * RX_CTX);
    localparam logic [15:0] A_RXP = 16'(`RX_PTR + `RX_STRIDE * RX_CTX);
    localparam logic [15:0] A_RXM = 16'(`RX_MATCH + `RX_STRIDE * RX_CTX);

    isoch_dma_pkg::state_s st;      // Registered state
    isoch_dma_pkg::state_s next_st; // Next state
    logic [31:0] rd_tx;             // Transmit control word as read
    logic [31:0] rd_rx;             // Receive control word as read
    logic [31:0] rd_mux;            // Addressed read value
    logic        hit;               // Address is mapped
    logic        wr;                // Write takes effect this edge
    logic        tx_go;             // Transmit start condition met
    logic        rx_go;             // Receive start condition met
    logic        chan_ok;           // Channel admitted
    logic        tag_ok;            // Tag admitted
    logic        sync_ok;           // Sync wait satisfied

    // One context step: software writes, engine events, start and stop
    function automatic isoch_dma_pkg::ctx_s step(
        input isoch_dma_pkg::ctx_s     c,
        input logic                    ws,
        input logic                    wc,
        input logic [31:0]             d,
        input logic                    gs,
        input logic                    gc,
        input logic                    go,
        input logic                    gclr,
        input isoch_dma_pkg::ctx_evt_s e
    );
        isoch_dma_pkg::ctx_s n;
        n = c;
        // Engine fetch drops wake; a software set in the same cycle wins
        if (e.fetch) begin
            n.wake = 1'b0;
        end
        if (ws) begin
            n.run  = c.run | d[`B_RUN];
            n.wake = n.wake | d[`B_WAKE];
            n.gate = c.gate | gs;
            if (d[`B_RUN] && !c.run) begin
                n.armed = 1'b1;
            end
        end
        if (wc) begin
            if (d[`B_RUN]) begin
                n.run  = 1'b0;
                n.dead = 1'b0;
            end
            if (gc) begin
                n.gate = 1'b0;
            end
        end
        // Start when armed or woken and the cycle gate allows
        if (c.run && !c.active && !c.dead && (c.armed || c.wake) && go) begin
            n.active = 1'b1;
            n.armed  = 1'b0;
            if (gclr) begin
                n.gate = 1'b0;
            end
        end
        // Engine ran out of descriptors
        if (e.idle) begin
            n.active = 1'b0;
        end
        if (e.done) begin
            n.code = e.code;
        end
        // Fatal error stops the context; it wins over a run clear
        if (e.fatal && c.run) begin
            n.dead   = 1'b1;
            n.active = 1'b0;
        end
        if (!n.run) begin
            n.active = 1'b0;
            n.armed  = 1'b0;
        end
        // Software reset drops run, active and armed; dead, wake and gate keep their values
        if (soft_reset) begin
            n.run    = 1'b0;
            n.active = 1'b0;
            n.armed  = 1'b0;
        end
        return n;
    endfunction

    // Control words assembled for reads
    always_comb begin
        rd_tx = `WORD_ZERO;
        rd_tx[`B_TX_GATE] = st.tx.gate;
        rd_tx[`B_TX_MATCH_HI:`B_TX_MATCH_LO] = st.tx_match;
        rd_tx[`B_RUN] = st.tx.run;
        rd_tx[`B_WAKE] = st.tx.wake;
        rd_tx[`B_DEAD] = st.tx.dead;
        rd_tx[`B_ACTIVE] = st.tx.active;
        rd_tx[`B_CODE_HI:`B_CODE_LO] = st.tx.code;
        rd_rx = `WORD_ZERO;
        rd_rx[`B_FILL] = st.fill;
        rd_rx[`B_HDR] = st.hdr;
        rd_rx[`B_RX_GATE] = st.rx.gate;
        rd_rx[`B_MULTI] = st.multi;
        rd_rx[`B_RUN] = st.rx.run;
        rd_rx[`B_WAKE] = st.rx.wake;
        rd_rx[`B_DEAD] = st.rx.dead;
        rd_rx[`B_ACTIVE] = st.rx.active;
        rd_rx[`B_SPD_HI:`B_SPD_LO] = st.spd;
        rd_rx[`B_CODE_HI:`B_CODE_LO] = st.rx.code;
    end

    // Address decode and read mux; both set and clear read the word
    always_comb begin
        hit = 1'b1;
        case (paddr)
            A_TXS, A_TXC:  rd_mux = rd_tx;
            A_TXP:         rd_mux = st.tx_ptr;
            A_RXS, A_RXC:  rd_mux = rd_rx;
            A_RXP:         rd_mux = st.rx_ptr;
            A_RXM:         rd_mux = st.rx_match;
            `MASK_HI_ADDR: rd_mux = st.mask_hi;
            `MASK_LO_ADDR: rd_mux = st.mask_lo;
            default: begin
                rd_mux = `WORD_ZERO;
                hit = 1'b0;
            end
        endcase
    end

    // Start gates and receive filter
    always_comb begin
        // Transmit: full 15-bit compare of low seconds and cycle index; receive: cycle index only
        tx_go = !st.tx.gate
              || (cyc.strobe && {cyc.seconds[1:0], cyc.cycle} == st.tx_match);
        rx_go = !st.rx.gate
              || (cyc.strobe
                  && cyc.cycle == st.rx_match[`B_RXCYC_HI:`B_RXCYC_LO]);
        if (st.multi) begin
            chan_ok = rx_pkt.channel[5] ? st.mask_hi[rx_pkt.channel[4:0]]
                                        : st.mask_lo[rx_pkt.channel[4:0]];
        end else begin
            chan_ok = rx_pkt.channel == st.rx_match[`B_CHAN_HI:`B_CHAN_LO];
        end
        tag_ok = st.rx_match[`B_TAG_LO + int'(rx_pkt.tag)];
        if (rx_pkt.tag == `TAG_ONE && st.rx_match[`B_TAG1_SYNC]) begin
            tag_ok = tag_ok && rx_pkt.sync[3:2] == `SYNC_TOP_OK;
        end
        sync_ok = !rx_wait_sync
               || rx_pkt.sync == st.rx_match[`B_SYNC_HI:`B_SYNC_LO];
    end

    // Next state
    always_comb begin
        next_st = st;
        wr = psel && penable && st.pready && pwrite && hit;
        // APB: answer in the first access cycle
        next_st.pready = psel && !penable;
        if (psel && !penable) begin
            next_st.prdata = rd_mux;
            next_st.pslverr = !hit;
        end
        next_st.tx = step(st.tx, wr && paddr == A_TXS, wr && paddr == A_TXC, pwdata,
                          pwdata[`B_TX_GATE], pwdata[`B_TX_GATE], tx_go, 1'b0, tx_evt);
        next_st.rx = step(st.rx, wr && paddr == A_RXS, wr && paddr == A_RXC, pwdata,
                          pwdata[`B_RX_GATE], pwdata[`B_RX_GATE], rx_go, 1'b1, rx_evt);
        // Transmit match value, set and clear semantics
        if (wr && paddr == A_TXS) begin
            next_st.tx_match = st.tx_match | pwdata[`B_TX_MATCH_HI:`B_TX_MATCH_LO];
        end
        if (wr && paddr == A_TXC) begin
            next_st.tx_match = st.tx_match & ~pwdata[`B_TX_MATCH_HI:`B_TX_MATCH_LO];
        end
        // Receive mode bits, set and clear semantics
        if (wr && paddr == A_RXS) begin
            next_st.fill  = st.fill | pwdata[`B_FILL];
            next_st.hdr   = st.hdr | pwdata[`B_HDR];
            next_st.multi = st.multi | pwdata[`B_MULTI];
        end
        if (wr && paddr == A_RXC) begin
            next_st.fill  = st.fill & ~pwdata[`B_FILL];
            next_st.hdr   = st.hdr & ~pwdata[`B_HDR];
            next_st.multi = st.multi & ~pwdata[`B_MULTI];
        end
        // Read-write registers; the receive match word keeps only the RXM_WMASK bits
        if (wr && paddr == A_TXP) begin
            next_st.tx_ptr = pwdata;
        end
        if (wr && paddr == A_RXP) begin
            next_st.rx_ptr = pwdata;
        end
        if (wr && paddr == A_RXM) begin
            next_st.rx_match = pwdata & `RXM_WMASK;
        end
        if (wr && paddr == `MASK_HI_ADDR) begin
            next_st.mask_hi = pwdata;
        end
        if (wr && paddr == `MASK_LO_ADDR) begin
            next_st.mask_lo = pwdata;
        end
        // Timestamp of the latest cycle start for packet trailers
        if (cyc.strobe) begin
            next_st.stamp = {cyc.seconds, cyc.cycle};
        end
        // Packet admission pulse and its speed
        next_st.accept = rx_pkt.valid && st.rx.active && chan_ok && tag_ok && sync_ok;
        if (next_st.accept) begin
            next_st.spd = rx_pkt.speed;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign prdata             = st.prdata;
    assign pready             = st.pready;
    assign pslverr            = st.pslverr;
    assign tx_active          = st.tx.active;
    assign tx_pointer         = st.tx_ptr;
    assign rx_active          = st.rx.active;
    assign rx_pointer         = st.rx_ptr;
    assign packed_buffer_mode = st.fill;
    assign keep_header_mode   = st.hdr;
    assign rx_accept          = st.accept;
    assign rx_timestamp       = st.stamp;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Checks
    run_rise_a: assert property ($rose(st.tx.run) |-> $past(wr && paddr == A_TXS))
        else $error("tx run set without software");
    run_fall_a: assert property ($fell(st.rx.run)
        |-> $past(soft_reset || (wr && paddr == A_RXC)))
        else $error("rx run cleared without software");
    wake_fetch_a: assert property (tx_evt.fetch && !(wr && paddr == A_TXS) |=> !st.tx.wake)
        else $error("wake survived fetch");
    dead_set_a: assert property (rx_evt.fatal && st.rx.run |=> st.rx.dead && !st.rx.active)
        else $error("fatal did not set dead");
    dead_clr_a: assert property (wr && paddr == A_TXC && pwdata[`B_RUN] && !tx_evt.fatal
        |=> !st.tx.dead)
        else $error("dead not cleared with run");
    tx_gate_a: assert property ($rose(st.tx.active) && $past(st.tx.gate)
        |-> $past(cyc.strobe && {cyc.seconds[1:0], cyc.cycle} == st.tx_match))
        else $error("gated tx started off cycle");
    rx_gate_a: assert property ($rose(st.rx.active) && $past(st.rx.gate)
        |-> !st.rx.gate && $past(cyc.cycle == st.rx_match[24:12]))
        else $error("rx gate wrong at start");
    chan_a: assert property (rx_accept |-> $past(st.multi || rx_pkt.channel == st.rx_match[5:0]))
        else $error("wrong channel accepted");
    tag_a: assert property (rx_accept |-> $past(st.rx_match[`B_TAG_LO + int'(rx_pkt.tag)]))
        else $error("disabled tag accepted");
    tag1_a: assert property (rx_accept && $past(rx_pkt.tag == 2'h1 && st.rx_match[6])
        |-> $past(rx_pkt.sync[3:2] == 2'h0))
        else $error("tag one sync filter bypassed");
    spd_a: assert property (rx_accept |-> st.spd == $past(rx_pkt.speed))
        else $error("speed not stored");
    apb_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing");
endmodule

// *** src/isoch_dma_params.svh ***
// Address map, field positions and constants of the isochronous context block
`ifndef ISOCH_DMA_PARAMS_SVH
`define ISOCH_DMA_PARAMS_SVH
`define TX_CTL_SET    16'h0200
`define TX_CTL_CLR    16'h0204
`define TX_PTR        16'h020C
`define TX_STRIDE     16'h0010
`define RX_CTL_SET    16'h0400
`define RX_CTL_CLR    16'h0404
`define RX_PTR        16'h040C
`define RX_MATCH      16'h410C
`define RX_STRIDE     16'h0020
`define MASK_HI_ADDR  16'h0078
`define MASK_LO_ADDR  16'h007C
`define B_TX_GATE     31
`define B_TX_MATCH_HI 30
`define B_TX_MATCH_LO 16
`define B_FILL        31
`define B_HDR         30
`define B_RX_GATE     29
`define B_MULTI       28
`define B_RUN         15
`define B_WAKE        12
`define B_DEAD        11
`define B_ACTIVE      10
`define B_SPD_HI      7
`define B_SPD_LO      5
`define B_CODE_HI     4
`define B_CODE_LO     0
`define B_TAG_LO      28
`define B_RXCYC_HI    24
`define B_RXCYC_LO    12
`define B_SYNC_HI     11
`define B_SYNC_LO     8
`define B_TAG1_SYNC   6
`define B_CHAN_HI     5
`define B_CHAN_LO     0
`define RXM_WMASK     32'hF1FF_FF7F
`define TAG_ONE       2'h1
`define SYNC_TOP_OK   2'h0
`define WORD_ZERO     32'h0000_0000
`endif

// *** src/isoch_dma_pkg.sv ***
// Types shared by the isochronous context control block
package isoch_dma_pkg;
    // Control state common to every context
    typedef struct packed {
        logic       run;
        logic       wake;
        logic       dead;
        logic       active;
        logic       armed;
        logic       gate;
        logic [4:0] code;
    } ctx_s;
    // Event pulses from the descriptor engine
    typedef struct packed {
        logic       fetch;
        logic       fatal;
        logic       done;
        logic       idle;
        logic [4:0] code;
    } ctx_evt_s;
    // Cycle start seen on the bus
    typedef struct packed {
        logic        strobe;
        logic [2:0]  seconds;
        logic [12:0] cycle;
    } cycle_start_s;
    // Header of a received isochronous packet
    typedef struct packed {
        logic       valid;
        logic [5:0] channel;
        logic [1:0] tag;
        logic [3:0] sync;
        logic [2:0] speed;
    } rx_pkt_s;
    // Whole block state
    typedef struct packed {
        ctx_s        tx;
        logic [14:0] tx_match;
        logic [31:0] tx_ptr;
        ctx_s        rx;
        logic        fill;
        logic        hdr;
        logic        multi;
        logic [2:0]  spd;
        logic [31:0] rx_ptr;
        logic [31:0] rx_match;
        logic [31:0] mask_hi;
        logic [31:0] mask_lo;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        accept;
        logic [15:0] stamp;
    } state_s;
endpackage

// *** tb/isoch_engine_model.sv ***
// Behavioural model of the descriptor engine and link side
`timescale 1ns/1ps
module isoch_engine_model (
    input  wire logic                  clk,
    output isoch_dma_pkg::cycle_start_s cyc,
    output isoch_dma_pkg::ctx_evt_s     tx_evt,
    output isoch_dma_pkg::ctx_evt_s     rx_evt,
    output isoch_dma_pkg::rx_pkt_s      rx_pkt,
    output logic                        rx_wait_sync
);
    // Quiet lines at time zero
    initial begin
        cyc = '0;
        tx_evt = '0;
        rx_evt = '0;
        rx_pkt = '0;
        rx_wait_sync = 1'b0;
    end
    // Cycle start pulse; stale fields show inverted values afterwards
    task automatic cycle_start(input logic [2:0] s, input logic [12:0] c);
        cyc <= {1'b1, s, c};
        @(posedge clk);
        cyc <= {1'b0, ~s, ~c};
        @(posedge clk);
    endtask
    // One-cycle engine event on either context
    task automatic event_pulse(input logic rx, input logic [8:0] v);
        if (rx) begin
            rx_evt <= v;
        end else begin
            tx_evt <= v;
        end
        @(posedge clk);
        rx_evt <= '0;
        tx_evt <= '0;
        @(posedge clk);
    endtask
    // Header pulse with its wait-field qualifier, then inverted leftovers
    task automatic packet(input logic [14:0] p, input logic ws);
        rx_pkt <= {1'b1, p};
        rx_wait_sync <= ws;
        @(posedge clk);
        rx_pkt <= {1'b0, ~p};
        rx_wait_sync <= ~ws;
        @(posedge clk);
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the isochronous context control block
`timescale 1ns/1ps
`include "isoch_dma_params.svh"
module tb;
    // Context 1 of each kind, to exercise the strides
    localparam logic [15:0] TS = `TX_CTL_SET + `TX_STRIDE;
    localparam logic [15:0] TC = `TX_CTL_CLR + `TX_STRIDE;
    localparam logic [15:0] TP = `TX_PTR + `TX_STRIDE;
    localparam logic [15:0] RS = `RX_CTL_SET + `RX_STRIDE;
    localparam logic [15:0] RC = `RX_CTL_CLR + `RX_STRIDE;
    localparam logic [15:0] RP = `RX_PTR + `RX_STRIDE;
    localparam logic [15:0] RM = `RX_MATCH + `RX_STRIDE;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, soft_reset;
    logic [15:0] paddr, rx_timestamp, lf;
    logic [31:0] pwdata, prdata, tx_pointer, rx_pointer, q, d, mv, hi, lo;
    isoch_dma_pkg::cycle_start_s cyc;
    isoch_dma_pkg::ctx_evt_s     tx_evt, rx_evt;
    isoch_dma_pkg::rx_pkt_s      rx_pkt;
    logic rx_wait_sync, tx_active, rx_active, rx_accept, ws, err, multi;
    logic packed_buffer_mode, keep_header_mode;
    logic [14:0] m, p;
    int n_errors, compares;
    // Device under test
    isoch_dma_context_control #(.TX_CTX(1), .RX_CTX(1)) dut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .soft_reset(soft_reset), .cyc(cyc), .tx_evt(tx_evt),
        .rx_evt(rx_evt), .rx_pkt(rx_pkt), .rx_wait_sync(rx_wait_sync),
        .tx_active(tx_active), .tx_pointer(tx_pointer), .rx_active(rx_active),
        .rx_pointer(rx_pointer), .packed_buffer_mode(packed_buffer_mode),
        .keep_header_mode(keep_header_mode), .rx_accept(rx_accept),
        .rx_timestamp(rx_timestamp));
    // Engine and link model
    isoch_engine_model eng (
        .clk(clk), .cyc(cyc), .tx_evt(tx_evt), .rx_evt(rx_evt),
        .rx_pkt(rx_pkt), .rx_wait_sync(rx_wait_sync));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Sixteen-bit LFSR stepping
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    // Expected admission of one header
    function automatic logic exp_acc(input logic [14:0] pk, input logic w);
        logic ok;
        if (multi) ok = pk[14] ? hi[pk[13:9]] : lo[pk[13:9]];
        else ok = (pk[14:9] == mv[5:0]);
        ok = ok & mv[28 + pk[8:7]];
        if (pk[8:7] == 2'h1 && mv[6] && pk[6:5] != 2'h0) ok = 1'b0;
        if (w && pk[6:3] != mv[11:8]) ok = 1'b0;
        return ok;
    endfunction
    // Count and compare
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // APB transfer; read data and error land in q and err
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] dw);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dw;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Random tags, sync, filter and channel; cycle field kept
    task automatic set_match();
        d = {rnd(), rnd()};
        mv = {d[31:28], 3'h0, mv[24:12], d[11:8], 1'b0, d[6:0]};
        apb(1'b1, RM, mv | 32'h0E00_0080);
        apb(1'b0, RM, 32'h0);
        chk(q, mv);
    endtask
    // Random headers against the filter model
    task automatic burst();
        for (int i = 0; i < 24; i++) begin
            d = {rnd(), rnd()};
            p = d[14:0];
            if (d[16]) p[14:9] = mv[5:0];
            if (d[17]) p[6:3] = mv[11:8];
            p[2:0] = 3'(d[20:18] % 3);
            ws = d[21];
            eng.packet(p, ws);
            chk(rx_accept, exp_acc(p, ws));
            if (rx_accept === 1'b1) begin
                apb(1'b0, RS, 32'h0);
                chk(q[7:5], p[2:0]);
            end
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
    // Main sequence
    initial begin
        n_errors = 0;
        compares = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        rstn = 1'b0;
        soft_reset = 1'b0;
        lf = 16'h0014;
        multi = 1'b0;
        mv = 32'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, TS, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, RS, 32'h0);
        chk(q, 32'h0);
        // Pointers keep what software wrote
        repeat (3) begin
            d = {rnd(), rnd()};
            apb(1'b1, TP, d);
            apb(1'b1, RP, ~d);
            apb(1'b0, TP, 32'h0);
            chk(q, d);
            chk(rx_pointer, ~d);
            chk(tx_pointer, d);
        end
        // Unmapped place refused both ways
        apb(1'b1, 16'h0FF0, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b0, 16'h0FF0, 32'h0);
        chk(err, 1'b1);
        chk(q, 32'h0);
        // Modes through set and clear addresses
        apb(1'b1, RS, 32'hD000_0000);
        apb(1'b0, RC, 32'h0);
        chk(q, 32'hD000_0000);
        chk({packed_buffer_mode, keep_header_mode}, 2'h3);
        apb(1'b1, RC, 32'h4000_0000);
        apb(1'b0, RS, 32'h0);
        chk(q, 32'h9000_0000);
        chk(keep_header_mode, 1'b0);
        apb(1'b1, RC, 32'h9000_0000);
        // Gated transmit start on the full 15-bit value
        d = {rnd(), rnd()};
        m = d[14:0];
        apb(1'b1, TS, {1'b1, m, 16'h8000});
        apb(1'b0, TC, 32'h0);
        chk(q, {1'b1, m, 16'h8000});
        eng.cycle_start({1'b0, m[14:13]}, m[12:0] + 13'h1);
        chk(tx_active, 1'b0);
        eng.cycle_start({1'b1, ~m[14:13]}, m[12:0]);
        chk(tx_active, 1'b0);
        eng.cycle_start({1'b1, m[14:13]}, m[12:0]);
        chk(tx_active, 1'b1);
        chk(rx_timestamp, {1'b1, m});
        // Wake set by software, dropped on fetch
        apb(1'b1, TS, 32'h0000_1000);
        apb(1'b0, TS, 32'h0);
        chk(q[12], 1'b1);
        eng.event_pulse(1'b0, 9'h100);
        apb(1'b0, TS, 32'h0);
        chk(q[12], 1'b0);
        repeat (3) begin
            d = {rnd(), rnd()};
            eng.event_pulse(1'b0, {4'h2, d[4:0]});
            apb(1'b0, TS, 32'h0);
            chk(q[4:0], d[4:0]);
        end
        // Fatal error, run untouched, then cleared by software
        eng.event_pulse(1'b0, 9'h080);
        apb(1'b0, TC, 32'h0);
        chk({q[15], q[11]}, 2'h3);
        apb(1'b1, TC, 32'h0000_8000);
        apb(1'b0, TS, 32'h0);
        chk(q & 32'h0000_8C00, 32'h0);
        // Receive waits for its cycle, gate then drops
        d = {rnd(), rnd()};
        mv[24:12] = d[28:16];
        set_match();
        apb(1'b1, RS, 32'h2000_8000);
        eng.cycle_start(3'h0, mv[24:12] + 13'h1);
        chk(rx_active, 1'b0);
        eng.cycle_start(3'h5, mv[24:12]);
        chk(rx_active, 1'b1);
        apb(1'b0, RS, 32'h0);
        chk(q[29], 1'b0);
        repeat (2) begin
            set_match();
            burst();
        end
        // Multi-channel in this context only, modes changed while stopped
        apb(1'b1, RC, 32'h0000_8000);
        apb(1'b1, RS, 32'h9000_0000);
        hi = {rnd(), rnd()};
        lo = {rnd(), rnd()};
        apb(1'b1, `MASK_HI_ADDR, hi);
        apb(1'b1, `MASK_LO_ADDR, lo);
        multi = 1'b1;
        apb(1'b1, RS, 32'h0000_8000);
        repeat (2) @(posedge clk);
        chk(rx_active, 1'b1);
        burst();
        // Software reset drops run
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        @(posedge clk);
        apb(1'b0, RS, 32'h0);
        chk(q[15], 1'b0);
        chk(rx_active, 1'b0);
        summarize();
    end
endmodule
